// >>> odl_map.svh
// Constants for the display RAM loader: command codes, word fields,
// font geometry and reset values.
// Assumes it is included by bare name from each file that needs it.
`ifndef ODL_MAP_SVH
`define ODL_MAP_SVH

// ****************************************************************
// Command byte patterns
// ****************************************************************
`define ODL_CMD_BANK_TAG   6'h1e
`define ODL_CMD_ATTR_TAG   3'h0
`define ODL_CMD_PTR_HI_TAG 4'h2
`define ODL_CMD_PTR_LO_TAG 4'h3
`define ODL_BANK_ONE       2'h0
`define ODL_BANK_TWO       2'h2

// ****************************************************************
// Display word layout and reserved codes
// ****************************************************************
`define ODL_CHAR_MSB       12
`define ODL_CHAR_LSB       5
`define ODL_ATTR_MSB       4
`define ODL_GLYPH_LAST     8'hfc
`define ODL_CODE_TEST      8'hfd
`define ODL_CODE_LINE_BRK  8'hfe
`define ODL_CODE_SPACE     8'hff

// ****************************************************************
// Font geometry: 12 dots by 19 rows, row 0 only for joining
// ****************************************************************
`define ODL_FONT_COLS      12
`define ODL_FONT_ROWS      19
`define ODL_ROW_JOIN       5'h00
`define ODL_ROW_LAST       5'h12

// ****************************************************************
// Reset values
// ****************************************************************
`define ODL_PTR_RESET      8'h00
`define ODL_ATTR_RESET     5'h00
`define ODL_GLYPH_RESET    8'h00
`define ODL_BANK_RESET     2'h0

`endif

// >>> odl_pkg.sv
// Types shared by the display RAM loader.
// Assumes nothing of its surroundings.
package odl_pkg;

    typedef enum logic [1:0] {
        code_glyph,
        code_test,
        code_line_break,
        code_space
    } odl_code_e;

endpackage : odl_pkg

// >>> odl_display_ram.sv
// Display memory: one write port, one registered read port.
// Assumes both ports run on the same clock as the loader.
module odl_display_ram #(
    parameter int DEPTH = 256,
    parameter int WIDTH = 13,
    parameter int AW    = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data_q,
    output logic                  rd_valid_q
);

    // Contents are not cleared at reset; software fills what it shows
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= '0;
        end else if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_en;
        end
    end

endmodule : odl_display_ram

// >>> odl_ram_loader.sv
// Display RAM loader: command decode, staging registers, display
// memory, code decoding and the pixel output stage.
// Assumes commands arrive as one-cycle byte strobes from the serial
// command interpreter on ref_clk; scan inputs are on ref_clk too.
//
// Function
// - Display memory holds 256 words of 13 bits.
// - Word bits 12..5 hold the code, bits 4..0 its attributes.
// - Codes 00h to fch select one of 253 glyphs.
// - Glyph: bits 4..1 foreground colour, bit 0 blink enable.
// - Code fdh is test only, never an ordinary glyph.
// - Code feh shows transparent and starts the next line.
// - Line break bits 4..3 give next line character size.
// - Line break bits 2..1 give spacing between rows.
// - Line break bit 0 ends the screen early.
// - Code ffh shows one transparent cell.
// - Space bits 4..1 latch background colour for following cells.
// - Space bit 0 enables the recording marker for following cells.
// - In retrace colour, intensity, fast blank and marker are off.
// - Fonts are 12 by 19; rows 1..18 visible, row 0 joins.
// - Commands 3 and 4 load pointer high and low nibbles.
// - Command 2 loads five attribute bits for word bits 4..0.
// - Attribute bits 7..5 are unused and reserved.
// - Command 1 loads the glyph byte for word bits 12..5.
// - Commands 1 or 5 write attribute and glyph to memory.
// - Each memory write increments the pointer by one.
// - Attribute staging survives writes.
// - Marker stays on until a space code clears it.
`include "odl_map.svh"

module odl_ram_loader #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire logic               cmd_valid,
    input  wire logic [7:0]         cmd_byte,
    input  wire logic               rd_en,
    input  wire logic [AW-1:0]      rd_addr,
    input  wire logic [4:0]         scan_row,
    input  wire logic               join_mode,
    input  wire logic               pixel_dot,
    input  wire logic               blink_phase,
    input  wire logic               retrace,
    output logic      [AW-1:0]      ram_write_pointer_q,
    output logic                    cell_valid_q,
    output odl_pkg::odl_code_e      code_type_q,
    output logic      [7:0]         glyph_code_q,
    output logic      [3:0]         fg_colour_q,
    output logic                    blink_q,
    output logic                    transparent_q,
    output logic                    new_line_q,
    output logic                    end_of_screen_q,
    output logic      [1:0]         line_size_q,
    output logic      [1:0]         line_spacing_q,
    output logic      [3:0]         bg_colour_q,
    output logic                    marker_en_q,
    output logic      [12:0]        font_addr_q,
    output logic                    font_row_vis_q,
    output logic                    red_q,
    output logic                    green_q,
    output logic                    blue_q,
    output logic                    intensity_q,
    output logic                    fast_blank_output_q,
    output logic                    recording_marker_output_q
);

    // ****************************************************************
    // Command decode
    // ****************************************************************
    logic [1:0]  bank_q;
    logic [4:0]  attribute_staging_q;
    logic [7:0]  glyph_staging_q;
    logic        is_bank;
    logic        is_attr;
    logic        is_ptr_hi;
    logic        is_ptr_lo;
    logic        is_glyph1;
    logic        is_glyph2;
    logic        do_write;
    logic [7:0]  glyph_d;
    logic [12:0] wr_word;

    always_comb begin
        is_bank   = cmd_valid && cmd_byte[7:2] == `ODL_CMD_BANK_TAG;
        is_attr   = cmd_valid && !bank_q[0]
                    && cmd_byte[7:5] == `ODL_CMD_ATTR_TAG;
        is_ptr_hi = cmd_valid && bank_q == `ODL_BANK_ONE
                    && cmd_byte[7:4] == `ODL_CMD_PTR_HI_TAG;
        is_ptr_lo = cmd_valid && bank_q == `ODL_BANK_ONE
                    && cmd_byte[7:4] == `ODL_CMD_PTR_LO_TAG;
        is_glyph1 = cmd_valid && bank_q == `ODL_BANK_ONE && cmd_byte[7];
        is_glyph2 = cmd_valid && bank_q == `ODL_BANK_TWO && cmd_byte[7];
        do_write  = is_glyph1 || is_glyph2;
        // Bank two reaches the lower half of the code space
        glyph_d   = is_glyph2 ? {1'b0, cmd_byte[6:0]} : cmd_byte;
        wr_word   = {glyph_d, attribute_staging_q};
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bank_q <= `ODL_BANK_RESET;
        end else if (is_bank) begin
            bank_q <= cmd_byte[1:0];
        end
    end

    // ****************************************************************
    // Staging registers
    // ****************************************************************
    // Only five bits are kept; the upper three are reserved
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            attribute_staging_q <= `ODL_ATTR_RESET;
        end else if (is_attr) begin
            attribute_staging_q <= cmd_byte[4:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            glyph_staging_q <= `ODL_GLYPH_RESET;
        end else if (do_write) begin
            glyph_staging_q <= glyph_d;
        end
    end

    // Commands never collide: a byte matches one pattern only
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ram_write_pointer_q <= `ODL_PTR_RESET;
        end else if (is_ptr_hi) begin
            ram_write_pointer_q[7:4] <= cmd_byte[3:0];
        end else if (is_ptr_lo) begin
            ram_write_pointer_q[3:0] <= cmd_byte[3:0];
        end else if (do_write) begin
            // Natural overflow of the 8-bit pointer gives the wrap
            ram_write_pointer_q <= ram_write_pointer_q + 8'h01;
        end
    end

    // ****************************************************************
    // Display memory
    // ****************************************************************
    logic [12:0] rd_word;
    logic        rd_valid;

    odl_display_ram #(
        .DEPTH (DEPTH),
        .WIDTH (13),
        .AW    (AW)
    ) u_ram (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .wr_en      (do_write),
        .wr_addr    (ram_write_pointer_q),
        .wr_data    (wr_word),
        .rd_en      (rd_en),
        .rd_addr    (rd_addr),
        .rd_data_q  (rd_word),
        .rd_valid_q (rd_valid)
    );

    // ****************************************************************
    // Code decode
    // ****************************************************************
    logic [7:0]         rd_char;
    logic [4:0]         rd_attr;
    odl_pkg::odl_code_e rd_type;

    always_comb begin
        rd_char = rd_word[`ODL_CHAR_MSB:`ODL_CHAR_LSB];
        rd_attr = rd_word[`ODL_ATTR_MSB:0];
        if (rd_char <= `ODL_GLYPH_LAST) begin
            rd_type = odl_pkg::code_glyph;
        end else if (rd_char == `ODL_CODE_TEST) begin
            rd_type = odl_pkg::code_test;
        end else if (rd_char == `ODL_CODE_LINE_BRK) begin
            rd_type = odl_pkg::code_line_break;
        end else begin
            rd_type = odl_pkg::code_space;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cell_valid_q  <= 1'b0;
            code_type_q   <= odl_pkg::code_glyph;
            glyph_code_q  <= 8'h00;
            fg_colour_q   <= 4'h0;
            blink_q       <= 1'b0;
            transparent_q <= 1'b0;
        end else begin
            cell_valid_q <= rd_valid;
            if (rd_valid) begin
                code_type_q   <= rd_type;
                glyph_code_q  <= rd_char;
                // Non-glyph cells carry no foreground
                fg_colour_q   <= (rd_type == odl_pkg::code_glyph)
                                 ? rd_attr[4:1] : 4'h0;
                blink_q       <= rd_type == odl_pkg::code_glyph
                                 && rd_attr[0];
                transparent_q <= rd_type != odl_pkg::code_glyph;
            end
        end
    end

    // Line break: pulses for the cell, settings held for next line
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            new_line_q      <= 1'b0;
            end_of_screen_q <= 1'b0;
            line_size_q     <= 2'h0;
            line_spacing_q  <= 2'h0;
        end else begin
            new_line_q      <= rd_valid
                               && rd_type == odl_pkg::code_line_break;
            end_of_screen_q <= rd_valid
                               && rd_type == odl_pkg::code_line_break
                               && rd_attr[0];
            if (rd_valid && rd_type == odl_pkg::code_line_break) begin
                line_size_q    <= rd_attr[4:3];
                line_spacing_q <= rd_attr[2:1];
            end
        end
    end

    // Space code settings persist until the next space code
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bg_colour_q <= 4'h0;
            marker_en_q <= 1'b0;
        end else if (rd_valid && rd_type == odl_pkg::code_space) begin
            bg_colour_q <= rd_attr[4:1];
            marker_en_q <= rd_attr[0];
        end
    end

    // ****************************************************************
    // Font row addressing
    // ****************************************************************
    // Row 0 is always addressed but visible only when two cells are stacked
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            font_addr_q    <= 13'h0000;
            font_row_vis_q <= 1'b0;
        end else begin
            font_addr_q    <= {glyph_code_q, scan_row};
            font_row_vis_q <= scan_row <= `ODL_ROW_LAST
                              && (scan_row != `ODL_ROW_JOIN
                                  || join_mode);
        end
    end

    // ****************************************************************
    // Pixel output
    // ****************************************************************
    logic       dot_on;
    logic [3:0] pix_colour;

    always_comb begin
        // Blinking hides the glyph during the off phase
        dot_on = pixel_dot && font_row_vis_q && !transparent_q
                 && !(blink_q && blink_phase);
        pix_colour = dot_on ? fg_colour_q : bg_colour_q;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            red_q                     <= 1'b0;
            green_q                   <= 1'b0;
            blue_q                    <= 1'b0;
            intensity_q               <= 1'b0;
            fast_blank_output_q       <= 1'b0;
            recording_marker_output_q <= 1'b0;
        end else if (retrace) begin
            red_q                     <= 1'b0;
            green_q                   <= 1'b0;
            blue_q                    <= 1'b0;
            intensity_q               <= 1'b0;
            fast_blank_output_q       <= 1'b0;
            recording_marker_output_q <= 1'b0;
        end else begin
            red_q                     <= pix_colour[3];
            green_q                   <= pix_colour[2];
            blue_q                    <= pix_colour[1];
            intensity_q               <= pix_colour[0];
            fast_blank_output_q       <= dot_on || bg_colour_q != 4'h0;
            recording_marker_output_q <= marker_en_q;
        end
    end

endmodule : odl_ram_loader

// >>> odl_ram_loader_sva.sv
// Checker for the display RAM loader, bound to its ports.
// Assumes one clock domain and commands as one-cycle strobes.
`include "odl_map.svh"

module odl_ram_loader_sva #(
    parameter int AW = 8
) (
    input wire logic               ref_clk,
    input wire logic               reset,
    input wire logic               cmd_valid,
    input wire logic [7:0]         cmd_byte,
    input wire logic               rd_en,
    input wire logic               retrace,
    input wire logic [AW-1:0]      ram_write_pointer_q,
    input wire logic               cell_valid_q,
    input wire odl_pkg::odl_code_e code_type_q,
    input wire logic [7:0]         glyph_code_q,
    input wire logic [3:0]         fg_colour_q,
    input wire logic               transparent_q,
    input wire logic               new_line_q,
    input wire logic               end_of_screen_q,
    input wire logic               marker_en_q,
    input wire logic               red_q,
    input wire logic               green_q,
    input wire logic               blue_q,
    input wire logic               intensity_q,
    input wire logic               fast_blank_output_q,
    input wire logic               recording_marker_output_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Bank tracking, so command decode can be judged from ports
    // ************************************************************
    logic [1:0] bank_q;
    logic       ptr_cmd;
    logic       wr_cmd;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bank_q <= `ODL_BANK_RESET;
        end else if (cmd_valid && cmd_byte[7:2] == `ODL_CMD_BANK_TAG) begin
            bank_q <= cmd_byte[1:0];
        end
    end

    assign ptr_cmd = cmd_valid && bank_q == `ODL_BANK_ONE;
    assign wr_cmd  = cmd_valid && cmd_byte[7] &&
                     (bank_q == `ODL_BANK_ONE || bank_q == `ODL_BANK_TWO);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ************************************************************
    // Assertions
    // ************************************************************
    a_ptr_hi_load: assert property (
        ptr_cmd && cmd_byte[7:4] == `ODL_CMD_PTR_HI_TAG |=>
        ram_write_pointer_q[7:4] == $past(cmd_byte[3:0]) &&
        ram_write_pointer_q[3:0] == $past(ram_write_pointer_q[3:0]))
        else $error("pointer high nibble load wrong");
    a_ptr_lo_load: assert property (
        ptr_cmd && cmd_byte[7:4] == `ODL_CMD_PTR_LO_TAG |=>
        ram_write_pointer_q[3:0] == $past(cmd_byte[3:0]) &&
        ram_write_pointer_q[7:4] == $past(ram_write_pointer_q[7:4]))
        else $error("pointer low nibble load wrong");
    a_write_ptr_inc: assert property (
        wr_cmd |=> ram_write_pointer_q ==
        AW'($past(ram_write_pointer_q) + 1'b1))
        else $error("pointer not advanced by one");
    a_ptr_idle_hold: assert property (
        !cmd_valid |=> $stable(ram_write_pointer_q))
        else $error("pointer moved without command");
    a_read_latency: assert property (
        rd_en |-> ##2 cell_valid_q)
        else $error("decoded cell late");
    a_retrace_dark: assert property (
        retrace |=> !(red_q || green_q || blue_q || intensity_q ||
        fast_blank_output_q || recording_marker_output_q))
        else $error("output active in retrace");
    a_eos_on_brk: assert property (
        end_of_screen_q |-> new_line_q &&
        code_type_q == odl_pkg::code_line_break)
        else $error("end of screen without line break");
    a_nonglyph_clear: assert property (
        cell_valid_q && code_type_q != odl_pkg::code_glyph |->
        transparent_q && fg_colour_q == 4'h0)
        else $error("reserved code not transparent");
    a_glyph_range: assert property (
        cell_valid_q && code_type_q == odl_pkg::code_glyph |->
        glyph_code_q <= `ODL_GLYPH_LAST)
        else $error("glyph type on reserved code");
    a_marker_sticky: assert property (
        $changed(marker_en_q) |->
        cell_valid_q && code_type_q == odl_pkg::code_space)
        else $error("marker changed without space code");

    c_space_read: cover property (
        cell_valid_q && code_type_q == odl_pkg::code_space);
    c_end_screen: cover property (end_of_screen_q);
    c_ptr_wrap: cover property (
        ram_write_pointer_q == 8'hff ##1 ram_write_pointer_q == 8'h00);
endmodule : odl_ram_loader_sva

bind odl_ram_loader odl_ram_loader_sva #(.AW(AW)) odl_ram_loader_sva_inst (.*);

// >>> odl_host_model.sv
// Host side model: issues command bytes as one-cycle strobes.
// Assumes the caller waits for reset release before the first call.
`include "odl_map.svh"

module odl_host_model (
    input wire logic ref_clk,
    output logic     cmd_valid,
    output logic [7:0] cmd_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Command tasks
    // ************************************************************
    initial begin
        cmd_valid = 1'b0;
        cmd_byte  = 8'h00;
    end

    // Idle byte is the inverse of the last, so stale data never helps
    task send(input logic [7:0] b);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_byte  <= b;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        cmd_byte  <= ~b;
    endtask : send

    task set_ptr(input logic [7:0] p);
        send({`ODL_CMD_PTR_HI_TAG, p[7:4]});
        send({`ODL_CMD_PTR_LO_TAG, p[3:0]});
    endtask : set_ptr

    task bank(input logic [1:0] b);
        send({`ODL_CMD_BANK_TAG, b});
    endtask : bank

    task attr(input logic [4:0] a);
        send({`ODL_CMD_ATTR_TAG, a});
    endtask : attr
endmodule : odl_host_model

// >>> odl_ram_loader_test.sv
// Testbench for the display RAM loader with a host command model.
// Assumes a 250 MHz clock and reset held for 16 cycles.
module odl_ram_loader_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Signals, instances, clock
    // ************************************************************
    logic ref_clk, reset, cmd_valid, rd_en, join_mode, pixel_dot;
    logic blink_phase, retrace, cell_v, blink, transp, nl, eos;
    logic marker, red, green, blue, inten, fb, rec, font_vis;
    logic [7:0] cmd_byte, rd_addr, ptr, glyph;
    logic [4:0] scan_row;
    logic [12:0] font_addr;
    logic [3:0] fg, bg;
    logic [1:0] lsize, lspace;
    odl_pkg::odl_code_e ctype;
    int error_cnt, total_checks;

    odl_host_model odl_host_model_inst (.ref_clk(ref_clk),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));
    odl_ram_loader odl_ram_loader_inst (.ref_clk(ref_clk),
        .reset(reset), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .rd_en(rd_en), .rd_addr(rd_addr), .scan_row(scan_row),
        .join_mode(join_mode), .pixel_dot(pixel_dot),
        .blink_phase(blink_phase), .retrace(retrace),
        .ram_write_pointer_q(ptr), .cell_valid_q(cell_v),
        .code_type_q(ctype), .glyph_code_q(glyph), .fg_colour_q(fg),
        .blink_q(blink), .transparent_q(transp), .new_line_q(nl),
        .end_of_screen_q(eos), .line_size_q(lsize),
        .line_spacing_q(lspace), .bg_colour_q(bg),
        .marker_en_q(marker), .font_addr_q(font_addr),
        .font_row_vis_q(font_vis),
        .red_q(red), .green_q(green), .blue_q(blue),
        .intensity_q(inten), .fast_blank_output_q(fb),
        .recording_marker_output_q(rec));

    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;

    // ************************************************************
    // Helpers
    // ************************************************************
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task report_and_stop;
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // Fields settle one edge after the read request is taken; the
    // cell strobe and line pulses stand for that one cycle only
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(cell_v, 1'b1);
    endtask : rd

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_pointer;
        odl_host_model_inst.send(8'h25);
        #1 chk(ptr, 8'h50);
        odl_host_model_inst.send(8'h34);
        #1 chk(ptr, 8'h54);
        odl_host_model_inst.bank(2'h1);
        odl_host_model_inst.send(8'h27);
        #1 chk(ptr, 8'h54);
        odl_host_model_inst.bank(2'h0);
        odl_host_model_inst.send(8'h27);
        #1 chk(ptr, 8'h74);
    endtask : t_pointer

    task t_write;
        odl_host_model_inst.set_ptr(8'h54);
        odl_host_model_inst.attr(5'h1b);
        odl_host_model_inst.send(8'h81);
        #1 chk(ptr, 8'h55);
        odl_host_model_inst.send(8'h90);
        odl_host_model_inst.bank(2'h2);
        odl_host_model_inst.send(8'hc5);
        odl_host_model_inst.bank(2'h0);
        #1 chk(ptr, 8'h57);
        rd(8'h54);
        chk({ctype, glyph, fg, blink}, {2'h0, 8'h81, 4'hd, 1'b1});
        rd(8'h55);
        chk({glyph, fg, blink}, {8'h90, 4'hd, 1'b1});
        rd(8'h56);
        chk({glyph, transp}, {8'h45, 1'b0});
    endtask : t_write

    task t_codes;
        odl_host_model_inst.set_ptr(8'h10);
        odl_host_model_inst.attr(5'h17);
        odl_host_model_inst.send(8'hfe);
        odl_host_model_inst.attr(5'h13);
        odl_host_model_inst.send(8'hff);
        odl_host_model_inst.send(8'hfd);
        odl_host_model_inst.attr(5'h00);
        odl_host_model_inst.send(8'hff);
        rd(8'h10);
        chk(ctype, odl_pkg::code_line_break);
        chk({transp, nl, eos, lsize, lspace}, 7'h7b);
        rd(8'h11);
        chk({ctype, transp, nl, lsize}, {2'h3, 1'b1, 1'b0, 2'h2});
        chk({bg, marker}, {4'h9, 1'b1});
        repeat (2) @(posedge ref_clk);
        #1 chk({rec, fb}, 2'h3);
        @(posedge ref_clk);
        retrace   <= 1'b1;
        pixel_dot <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 chk({red, green, blue, inten, fb, rec}, 6'h00);
        @(posedge ref_clk);
        retrace   <= 1'b0;
        pixel_dot <= 1'b0;
        rd(8'h12);
        chk({ctype, transp, fg, marker}, {2'h1, 1'b1, 4'h0, 1'b1});
        rd(8'h13);
        chk({ctype, bg, marker}, {2'h3, 4'h0, 1'b0});
    endtask : t_codes

    task t_wrap;
        odl_host_model_inst.set_ptr(8'hff);
        odl_host_model_inst.send(8'h82);
        #1 chk(ptr, 8'h00);
        rd(8'hff);
        chk({ctype, glyph, fg}, {2'h0, 8'h82, 4'h0});
    endtask : t_wrap

    // Row 0 shows only when stacking; the blink off phase hides dots
    task t_font;
        rd(8'h54);
        @(posedge ref_clk);
        scan_row  <= 5'h00;
        join_mode <= 1'b0;
        pixel_dot <= 1'b1;
        @(posedge ref_clk);
        join_mode <= 1'b1;
        #1 chk({font_addr, font_vis}, {13'h1020, 1'b0});
        @(posedge ref_clk);
        #1 chk(font_vis, 1'b1);
        @(posedge ref_clk);
        blink_phase <= 1'b1;
        #1 chk({red, green, blue, inten, fb}, 5'h1b);
        @(posedge ref_clk);
        blink_phase <= 1'b0;
        scan_row    <= 5'h13;
        #1 chk({red, green, blue, inten, fb}, 5'h00);
        @(posedge ref_clk);
        #1 chk({font_addr, font_vis}, {13'h1033, 1'b0});
        @(posedge ref_clk);
        scan_row  <= 5'h05;
        join_mode <= 1'b0;
        pixel_dot <= 1'b0;
        #1 chk({red, green, blue, inten, fb}, 5'h00);
    endtask : t_font

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        reset       = 1'b1;
        rd_en       = 1'b0;
        rd_addr     = 8'h00;
        scan_row    = 5'h05;
        join_mode   = 1'b0;
        pixel_dot   = 1'b0;
        blink_phase = 1'b0;
        retrace     = 1'b0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        t_pointer();
        t_write();
        t_codes();
        t_wrap();
        t_font();
        report_and_stop();
    end

    // The whole sequence needs about a hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        report_and_stop();
    end
endmodule : odl_ram_loader_test
